// [mdfp_top.sv]
// fault protection and mode control of a three-phase motor driver
//
// Behaviour
// - overvoltage: all fets off, fault pin low
// - overvoltage flags latch; drive resumes when clear
// - overvoltage protection gated by enable bit; pin variant always on
// - overvoltage threshold picked by level bit; pin variant fixed at 34
// - overcurrent needs deglitch; pin variant fixed
// - two-bit response field selects four modes
// - latched mode: off until clear command
// - retry mode: restore after retry interval
// - report mode: fault pin only, drivers run
// - buck overcurrent: buck off, auto retry
// - warning sets overtemp and warning flags
// - warning drives fault pin only if enabled
// - warning flag clears on clear when cool
// - fet thermal shutdown: fets, pump off
// - die thermal shutdown also stops buck
// - sleep after falling edge plus delay
// - pin high: operating mode after wake delay
// - fault pin low while regulators switch
// - clear command ends latched fault state
// - short sleep pin pulse clears faults
// - driver kill pin forces fets off
// - driver kill may pull fault pin low
`timescale 1ns/100ps
`default_nettype none
module mdfp_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic pin_variant,
	input wire logic ov_above_22,
	input wire logic ov_above_34,
	input wire logic [5:0] oc_raw,
	input wire logic buck_oc_raw,
	input wire logic warn_above_trip,
	input wire logic warn_below_hys,
	input wire logic tsd_fet_hot,
	input wire logic tsd_die_hot,
	input wire logic sleep_bar_pin,
	input wire logic driver_kill_pin,
	input wire logic [2:0] high_side_input,
	input wire logic [2:0] low_side_input,
	output logic [2:0] high_side_gate,
	output logic [2:0] low_side_gate,
	output logic fault_out_low_out,
	output logic fault_out_low_oe_n,
	output logic buck_en,
	output logic charge_pump_en,
	output logic regulators_en,
	output logic asleep
);
	mdfp_pkg::mdfp_mode_t mode_q, mode_d;
	logic [7:0] ctrl_q;
	logic [11:0] low_cnt_q;
	logic pin_q;
	logic ov_flag_q, oc_flag_q, bk_flag_q, bkoc_flag_q;
	logic ot_flag_q, warn_flag_q, tsd_flag_q, fault_flag_q;
	logic [5:0] fet_flag_q;
	logic oc_lock_q, oc_report_q, warn_pull_q;
	logic [2:0] hs_q, ls_q;
	logic fault_pull_q;
	logic [31:0] rdata_q;
	logic err_q;

	// bus decode
	wire setup = psel && !penable;
	wire wr_go = psel && penable && pwrite;
	wire hit_sum = paddr == mdfp_pkg::SUMMARY_OFF;
	wire hit_fet = paddr == mdfp_pkg::FETSTAT_OFF;
	wire hit_th = paddr == mdfp_pkg::THERM_OFF;
	wire hit_ctl = paddr == mdfp_pkg::CTRL_OFF;
	wire mapped = hit_sum || hit_fet || hit_th || hit_ctl;
	wire ctl_wr = wr_go && hit_ctl && pstrb[0];
	wire clr_cmd = ctl_wr && pwdata[mdfp_pkg::CT_CLR];

	// sleep pin pulse and sleep entry timing
	wire running = mode_q == mdfp_pkg::MD_RUN;
	wire pin_rise = sleep_bar_pin && !pin_q;
	wire rst_pulse = pin_rise && running && (low_cnt_q <= mdfp_pkg::RST_WIN_CYC);
	wire go_sleep = !sleep_bar_pin && (low_cnt_q >= mdfp_pkg::SLEEP_CYC);
	// past the reset window the regulators are winding down
	wire powering_down = running && !sleep_bar_pin && (low_cnt_q > mdfp_pkg::RST_WIN_CYC);
	wire clr = clr_cmd || rst_pulse;
	wire wake_busy;

	// configuration views; the pin variant ignores the register except the warning report bit
	wire ov_on = pin_variant || ctrl_q[mdfp_pkg::CT_OVON];
	wire ov_hi = pin_variant || ctrl_q[mdfp_pkg::CT_OVLVL];
	wire [1:0] resp = pin_variant ? mdfp_pkg::OC_LATCH : ctrl_q[mdfp_pkg::CT_RESP +: 2];
	wire deg_alt = !pin_variant && ctrl_q[mdfp_pkg::CT_DEG];
	wire [11:0] deg_lim = deg_alt ? mdfp_pkg::OC_DEG_ALT_CYC : mdfp_pkg::OC_DEG_CYC;
	wire warn_rep = ctrl_q[mdfp_pkg::CT_WREP];

	// fault conditions
	wire ov_cond = running && ov_on && (ov_hi ? ov_above_34 : ov_above_22);
	wire [5:0] oc_hit;
	wire bk_hit;
	// overcurrent faults are ignored while the kill pin holds the fets
	wire oc_seen = running && !driver_kill_pin && (|oc_hit);
	wire oc_act = oc_seen && (resp != mdfp_pkg::OC_OFF);
	wire oc_start_retry = oc_act && (resp == mdfp_pkg::OC_RETRY);
	wire retry_busy;
	wire bk_busy_w;
	wire bk_start = running && bk_hit && !bk_busy_w;
	wire tsd_any = tsd_fet_hot || tsd_die_hot;
	wire any_cond = ov_cond || oc_seen || bk_hit || tsd_any || warn_above_trip;

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_oc
			mdfp_deglitch u_deg (
				.pclk(pclk),
				.presetn(presetn),
				.raw(oc_raw[g]),
				.limit(deg_lim),
				.hit(oc_hit[g])
			);
		end
	endgenerate

	mdfp_deglitch u_bk_deg (
		.pclk(pclk),
		.presetn(presetn),
		.raw(buck_oc_raw),
		.limit(mdfp_pkg::BK_DEG_CYC),
		.hit(bk_hit)
	);

	mdfp_timer u_retry (
		.pclk(pclk),
		.presetn(presetn),
		.start(oc_start_retry && !retry_busy),
		.length(mdfp_pkg::RETRY_CYC),
		.busy(retry_busy)
	);

	mdfp_timer u_bk_retry (
		.pclk(pclk),
		.presetn(presetn),
		.start(bk_start),
		.length(mdfp_pkg::BK_RETRY_CYC),
		.busy(bk_busy_w)
	);

	mdfp_timer u_wake (
		.pclk(pclk),
		.presetn(presetn),
		.start(mode_q == mdfp_pkg::MD_SLEEP && sleep_bar_pin),
		.length(mdfp_pkg::WAKE_CYC),
		.busy(wake_busy)
	);

	// mode sequencing
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			mdfp_pkg::MD_WAKE: begin
				if (go_sleep) begin
					mode_d = mdfp_pkg::MD_SLEEP;
				end else if (!wake_busy && sleep_bar_pin) begin
					mode_d = mdfp_pkg::MD_RUN;
				end
			end
			mdfp_pkg::MD_RUN: begin
				if (go_sleep) begin
					mode_d = mdfp_pkg::MD_SLEEP;
				end
			end
			default: begin
				if (sleep_bar_pin) begin
					mode_d = mdfp_pkg::MD_WAKE;
				end
			end
		endcase
	end

	wire fets_off = !running || driver_kill_pin || ov_cond || oc_lock_q || retry_busy
		|| (oc_act && resp != mdfp_pkg::OC_REPORT) || tsd_any;
	wire fault_pull = ov_cond || oc_lock_q || retry_busy || oc_report_q || oc_act
		|| bk_busy_w || bk_start || tsd_any || (warn_rep && warn_pull_q)
		|| (running && driver_kill_pin)
		|| powering_down || (mode_q == mdfp_pkg::MD_WAKE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= mdfp_pkg::MD_WAKE;
			// idle high, so leaving reset shows no false rising edge
			pin_q <= 1'b1;
			low_cnt_q <= 12'h000;
		end else begin
			mode_q <= mode_d;
			pin_q <= sleep_bar_pin;
			low_cnt_q <= sleep_bar_pin ? 12'h000
				: (low_cnt_q == mdfp_pkg::SLEEP_CYC) ? low_cnt_q : low_cnt_q + 12'h001;
		end
	end

	// configuration, back to defaults in sleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= mdfp_pkg::CTRL_RST;
		end else if (mode_q == mdfp_pkg::MD_SLEEP) begin
			ctrl_q <= mdfp_pkg::CTRL_RST;
		end else if (ctl_wr) begin
			ctrl_q <= {1'b0, pwdata[6:0]} & 8'h3F;
		end
	end

	// overcurrent state; a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oc_lock_q <= 1'b0;
			oc_report_q <= 1'b0;
		end else begin
			oc_lock_q <= (oc_act && resp == mdfp_pkg::OC_LATCH)
				|| (oc_lock_q && !(clr && !oc_seen));
			oc_report_q <= (oc_act && resp == mdfp_pkg::OC_REPORT)
				|| (oc_report_q && !(clr && !oc_seen));
		end
	end

	// status flags, all but the buck flags latched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ov_flag_q <= 1'b0;
			oc_flag_q <= 1'b0;
			fet_flag_q <= 6'h00;
			bk_flag_q <= 1'b0;
			bkoc_flag_q <= 1'b0;
			warn_flag_q <= 1'b0;
			tsd_flag_q <= 1'b0;
			ot_flag_q <= 1'b0;
			fault_flag_q <= 1'b0;
		end else begin
			ov_flag_q <= ov_cond || (ov_flag_q && !(clr && !ov_cond));
			oc_flag_q <= oc_act || (oc_flag_q && !(clr && !oc_seen));
			fet_flag_q <= (oc_act ? oc_hit : 6'h00)
				| (fet_flag_q & ~((clr && !oc_seen) ? 6'h3F : 6'h00));
			// buck flags fall by themselves when the retry interval ends
			bk_flag_q <= bk_start || (bk_flag_q && bk_busy_w);
			bkoc_flag_q <= bk_start || (bkoc_flag_q && bk_busy_w);
			warn_flag_q <= warn_above_trip || (warn_flag_q && !clr);
			tsd_flag_q <= tsd_any || (tsd_flag_q && !(clr && !tsd_any));
			ot_flag_q <= warn_above_trip || tsd_any
				|| (ot_flag_q && !(clr && !any_cond));
			fault_flag_q <= ov_cond || oc_act || bk_start || tsd_any
				|| (fault_flag_q && !(clr && !any_cond));
		end
	end

	// warning pull-down has its own hysteresis release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warn_pull_q <= 1'b0;
		end else begin
			warn_pull_q <= warn_above_trip || (warn_pull_q && !warn_below_hys);
		end
	end

	// gate drive and open-drain fault pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_q <= 3'h0;
			ls_q <= 3'h0;
			fault_pull_q <= 1'b0;
		end else begin
			hs_q <= fets_off ? 3'h0 : high_side_input;
			ls_q <= fets_off ? 3'h0 : low_side_input;
			fault_pull_q <= fault_pull;
		end
	end

	assign high_side_gate = hs_q;
	assign low_side_gate = ls_q;
	assign fault_out_low_out = 1'b0;
	assign fault_out_low_oe_n = !fault_pull_q;
	// die shutdown stops the buck, either sensor stops the pump
	assign buck_en = running && !bk_busy_w && !tsd_die_hot;
	assign charge_pump_en = running && !tsd_any;
	assign regulators_en = mode_q != mdfp_pkg::MD_SLEEP;
	assign asleep = mode_q == mdfp_pkg::MD_SLEEP;

	// register read mux
	wire [31:0] sum_word = {25'h0000000, bk_flag_q, 1'b0, oc_flag_q, 1'b0,
		ov_flag_q, ot_flag_q, fault_flag_q};
	wire [31:0] fet_word = {25'h0000000, bkoc_flag_q, fet_flag_q};
	wire [31:0] th_word = {30'h00000000, tsd_flag_q, warn_flag_q};
	wire [31:0] ctl_word = {24'h000000, ctrl_q};
	wire [31:0] rd_mux = hit_sum ? sum_word : hit_fet ? fet_word
		: hit_th ? th_word : hit_ctl ? ctl_word : 32'h00000000;

	// read data sampled in setup so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end else if (setup) begin
			rdata_q <= pwrite ? 32'h00000000 : rd_mux;
			err_q <= !mapped;
		end
	end

	assign pready = 1'b1;
	assign prdata = rdata_q;
	assign pslverr = psel && penable && err_q;

	// run lengths of the retry and wake timers; the intervals exceed what a delay range may span
	logic [11:0] retry_run_q;
	logic [11:0] wake_run_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_run_q <= 12'h000;
			wake_run_q <= 12'h000;
		end else begin
			retry_run_q <= retry_busy ? retry_run_q + 12'h001 : 12'h000;
			wake_run_q <= wake_busy ? wake_run_q + 12'h001 : 12'h000;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ov_fets_off: assert property (ov_cond |=> hs_q == 3'h0 && ls_q == 3'h0 && fault_pull_q)
		else $error("fets still driven during overvoltage");
	a_ov_flag_hold: assert property (ov_flag_q && !clr |=> ov_flag_q)
		else $error("overvoltage flag dropped without clear");
	a_ov_gate_off: assert property (!pin_variant && !ctrl_q[mdfp_pkg::CT_OVON] |-> !ov_cond)
		else $error("overvoltage active while disabled");
	a_oc_disabled_mode: assert property (resp == mdfp_pkg::OC_OFF |-> !oc_act)
		else $error("overcurrent acted in disabled mode");
	a_oc_latch_hold: assert property (oc_lock_q && !clr |=> oc_lock_q ##1 hs_q == 3'h0)
		else $error("latched shutdown released without clear");
	a_oc_retry_ends: assert property (retry_run_q <= mdfp_pkg::RETRY_CYC)
		else $error("retry interval did not end");
	a_oc_report_runs: assert property (oc_act && resp == mdfp_pkg::OC_REPORT && !ov_cond
		&& !tsd_any && !oc_lock_q && !retry_busy && !driver_kill_pin |=> fault_pull_q)
		else $error("report mode did not pull fault pin");
	a_buck_off: assert property (bk_start |=> !buck_en && bkoc_flag_q)
		else $error("buck not stopped on overcurrent");
	a_warn_keep: assert property (warn_flag_q && warn_above_trip |=> warn_flag_q)
		else $error("warning flag cleared while hot");
	a_wake_release: assert property (wake_run_q <= mdfp_pkg::WAKE_CYC)
		else $error("wake hold-off too long");
	a_kill_fets: assert property (driver_kill_pin |=> hs_q == 3'h0 && ls_q == 3'h0)
		else $error("fets on while kill pin high");
	a_clear_sum: assert property (clr && !any_cond && !bk_start |=> !fault_flag_q)
		else $error("summary flag not cleared");

	c_oc_latch: cover property (oc_act && resp == mdfp_pkg::OC_LATCH);
	c_sleep_entry: cover property (mode_q == mdfp_pkg::MD_RUN ##1 mode_q == mdfp_pkg::MD_SLEEP);
	c_rst_pulse: cover property (rst_pulse && oc_lock_q);
	c_buck_retry: cover property ($fell(bk_busy_w));
endmodule // mdfp_top
`default_nettype wire

// [mdfp_pkg.sv]
// constants and types shared by the motor driver protection block
`default_nettype none
package mdfp_pkg;
	localparam int CLK_MHZ = 250;
	// apb byte offsets
	localparam logic [7:0] SUMMARY_OFF = 8'h00;
	localparam logic [7:0] FETSTAT_OFF = 8'h04;
	localparam logic [7:0] THERM_OFF = 8'h08;
	localparam logic [7:0] CTRL_OFF = 8'h0C;
	// summary_status_reg fields
	localparam int SUM_FAULT = 0;
	localparam int SUM_OT = 1;
	localparam int SUM_OV = 2;
	localparam int SUM_OC = 4;
	localparam int SUM_BK = 6;
	// fet status: per-fet flags in [5:0], buck overcurrent here
	localparam int FET_BKOC = 6;
	// thermal status fields
	localparam int TH_WARN = 0;
	localparam int TH_SD = 1;
	// control fields
	localparam int CT_OVON = 0;
	localparam int CT_OVLVL = 1;
	localparam int CT_RESP = 2;
	localparam int CT_DEG = 4;
	localparam int CT_WREP = 5;
	localparam int CT_CLR = 6;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// overcurrent responses
	localparam logic [1:0] OC_LATCH = 2'h0;
	localparam logic [1:0] OC_RETRY = 2'h1;
	localparam logic [1:0] OC_REPORT = 2'h2;
	localparam logic [1:0] OC_OFF = 2'h3;
	// times in ns; least times round up, the reset window rounds down
	localparam int OC_DEG_NS = 600;
	localparam int OC_DEG_ALT_NS = 1200;
	localparam int BK_DEG_NS = 1000;
	localparam int RETRY_NS = 4000;
	localparam int BK_RETRY_NS = 4000;
	localparam int SLEEP_NS = 4000;
	localparam int WAKE_NS = 4000;
	localparam int RST_WIN_NS = 2000;
	localparam logic [11:0] OC_DEG_CYC = 12'((OC_DEG_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OC_DEG_ALT_CYC = 12'((OC_DEG_ALT_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] BK_DEG_CYC = 12'((BK_DEG_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] RETRY_CYC = 12'((RETRY_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] BK_RETRY_CYC = 12'((BK_RETRY_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] SLEEP_CYC = 12'((SLEEP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] WAKE_CYC = 12'((WAKE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] RST_WIN_CYC = 12'(RST_WIN_NS * CLK_MHZ / 1000);
	typedef enum logic [1:0] {MD_WAKE, MD_RUN, MD_SLEEP} mdfp_mode_t;
endpackage
`default_nettype wire

// [mdfp_deglitch.sv]
// qualifies a raw level that must persist longer than a cycle count
`timescale 1ns/100ps
`default_nettype none
module mdfp_deglitch (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic raw,
	input wire logic [11:0] limit,
	output logic hit
);
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;
	// saturate so a long fault never wraps back to zero
	assign cnt_d = !raw ? 12'h000 : (cnt_q == limit) ? cnt_q : cnt_q + 12'h001;
	assign hit = raw && (cnt_q == limit);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 12'h000;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // mdfp_deglitch
`default_nettype wire

// [mdfp_timer.sv]
// one-shot interval timer, busy from start until the count runs out
`timescale 1ns/100ps
`default_nettype none
module mdfp_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [11:0] length,
	output logic busy
);
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;
	assign cnt_d = start ? length : (cnt_q != 12'h000) ? cnt_q - 12'h001 : cnt_q;
	assign busy = cnt_q != 12'h000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 12'h000;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // mdfp_timer
`default_nettype wire

// [mdfp_mcu_model.sv]
// model of the motor controller that drives sleep, kill and phase pins
`timescale 1ns/100ps
`default_nettype none
module mdfp_mcu_model (
	input wire logic pclk,
	input wire logic fault_pin,
	output logic sleep_bar_pin,
	output logic driver_kill_pin,
	output logic [2:0] high_side_input,
	output logic [2:0] low_side_input
);
	localparam int WAIT = int'(mdfp_pkg::WAKE_CYC) + 2;
	localparam int WIN = int'(mdfp_pkg::RST_WIN_CYC);
	int wake_c = WAIT;
	int low_c = 0;
	logic cut = 1'b0;
	logic drive;
	initial sleep_bar_pin = 1'b1;
	initial driver_kill_pin = 1'b0;
	// only a long low restarts the wake wait; a reset pulse keeps driving
	always @(posedge pclk) begin
		low_c <= sleep_bar_pin ? 0 : low_c + 1;
		if (sleep_bar_pin && low_c > WIN)
			wake_c <= 0;
		else if (sleep_bar_pin && wake_c < WAIT)
			wake_c <= wake_c + 1;
	end
	assign drive = (wake_c == WAIT) && !cut;
	assign high_side_input = drive ? 3'h5 : 3'h0;
	assign low_side_input = drive ? 3'h2 : 3'h0;
	task automatic pin(input logic v);
		sleep_bar_pin <= v;
	endtask
	// low time clipped to the window, else the pulse would not count as a reset pulse
	task automatic pulse(input int n);
		sleep_bar_pin <= 1'b0;
		repeat ((n > WIN) ? WIN : n) @(posedge pclk);
		sleep_bar_pin <= 1'b1;
	endtask
	task automatic kill(input logic v);
		driver_kill_pin <= v;
	endtask
	// acts only if the pin already shows the report when called; it does not wait
	task automatic take_over(input logic on);
		cut <= on && !fault_pin;
	endtask
endmodule // mdfp_mcu_model
`default_nettype wire

// [mdfp_bench.sv]
// self-checking bench for the motor driver protection block
`timescale 1ns/100ps
`default_nettype none
module mdfp_bench;
	localparam logic [7:0] SUM = mdfp_pkg::SUMMARY_OFF;
	localparam logic [7:0] FET = mdfp_pkg::FETSTAT_OFF;
	localparam logic [7:0] THM = mdfp_pkg::THERM_OFF;
	localparam logic [7:0] CTL = mdfp_pkg::CTRL_OFF;
	localparam logic [31:0] RUNG = 32'h2A;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic pin_variant = 1'b0;
	logic ov_above_22 = 1'b0;
	logic ov_above_34 = 1'b0;
	logic [5:0] oc_raw = 6'h00;
	logic buck_oc_raw = 1'b0;
	logic warn_above_trip = 1'b0;
	logic warn_below_hys = 1'b1;
	logic tsd_fet_hot = 1'b0;
	logic tsd_die_hot = 1'b0;
	logic pready, pslverr, sleep_bar_pin, driver_kill_pin;
	logic [31:0] prdata;
	logic [2:0] high_side_input, low_side_input, high_side_gate, low_side_gate;
	logic fault_out_low_out, fault_out_low_oe_n, buck_en, charge_pump_en, regulators_en, asleep;
	logic [31:0] rdat;
	logic rerr;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	// open-drain fault line with its pull-up
	wire logic fault_pin = fault_out_low_oe_n ? 1'b1 : fault_out_low_out;
	mdfp_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .pready,
		.prdata, .pslverr, .pin_variant, .ov_above_22, .ov_above_34, .oc_raw, .buck_oc_raw,
		.warn_above_trip, .warn_below_hys, .tsd_fet_hot, .tsd_die_hot, .sleep_bar_pin,
		.driver_kill_pin, .high_side_input, .low_side_input, .high_side_gate, .low_side_gate,
		.fault_out_low_out, .fault_out_low_oe_n, .buck_en, .charge_pump_en, .regulators_en,
		.asleep);
	mdfp_mcu_model mcu (.pclk, .fault_pin, .sleep_bar_pin, .driver_kill_pin, .high_side_input,
		.low_side_input);
	always #2 pclk = ~pclk;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			$display("ERROR at %0t: run did not end", $time);
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic b1(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask
	task automatic gt(input logic [31:0] exp);
		chk({26'h0, high_side_gate, low_side_gate}, exp);
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// extra edge at the end so a following call never re-drives psel in one step
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		apb(a, 1'b0, 32'h0);
		chk(rdat & m, e);
	endtask
	initial begin
		cy(4);
		presetn <= 1'b1;
		cy(4);
		b1(fault_out_low_oe_n, 1'b1);
		rd(SUM, 32'h0);
		rd(CTL, 32'(mdfp_pkg::CTRL_RST));
		rd(8'h10, 32'h0);
		b1(rerr, 1'b1);
		done("reset");
		ov_above_34 <= 1'b1;
		cy(4);
		b1(fault_out_low_oe_n, 1'b1);
		ov_above_34 <= 1'b0;
		ov_above_22 <= 1'b1;
		wr(CTL, 32'h03);
		cy(4);
		b1(fault_out_low_oe_n, 1'b1);
		wr(CTL, 32'h01);
		cy(3);
		gt(32'h0);
		b1(fault_out_low_oe_n, 1'b0);
		rd(SUM, 32'h05);
		ov_above_22 <= 1'b0;
		cy(3);
		gt(RUNG);
		b1(fault_out_low_oe_n, 1'b1);
		rd(SUM, 32'h05);
		wr(CTL, 32'h40);
		rd(SUM, 32'h0);
		pin_variant <= 1'b1;
		ov_above_22 <= 1'b1;
		cy(4);
		b1(fault_out_low_oe_n, 1'b1);
		ov_above_34 <= 1'b1;
		cy(3);
		b1(fault_out_low_oe_n, 1'b0);
		ov_above_22 <= 1'b0;
		ov_above_34 <= 1'b0;
		pin_variant <= 1'b0;
		wr(CTL, 32'h40);
		done("overvoltage");
		for (int m = 0; m < 4; m++) begin
			wr(CTL, 32'(m << 2));
			oc_raw <= 6'h01;
			cy(140);
			oc_raw <= 6'h00;
			cy(4);
			b1(fault_out_low_oe_n, 1'b1);
			oc_raw <= 6'h01;
			cy(160);
			b1(fault_out_low_oe_n, m == 3);
			gt(m < 2 ? 32'h0 : RUNG);
			oc_raw <= 6'h00;
			cy(10);
			gt(m < 2 ? 32'h0 : RUNG);
			b1(fault_out_low_oe_n, m == 3);
			rd(FET, m == 3 ? 32'h0 : 32'h01);
			rd(SUM, m == 3 ? 32'h0 : 32'h11);
			if (m == 1) begin
				cy(int'(mdfp_pkg::RETRY_CYC));
				gt(RUNG);
				b1(fault_out_low_oe_n, 1'b1);
				rd(FET, 32'h01);
			end
			if (m == 2) begin
				mcu.take_over(1'b1);
				cy(3);
				gt(32'h0);
				mcu.take_over(1'b0);
			end
			wr(CTL, 32'(m << 2) | 32'h40);
			cy(3);
			b1(fault_out_low_oe_n, 1'b1);
			gt(RUNG);
			rd(SUM, 32'h0);
		end
		done("overcurrent");
		buck_oc_raw <= 1'b1;
		cy(int'(mdfp_pkg::BK_DEG_CYC) + 20);
		b1(buck_en, 1'b0);
		b1(fault_out_low_oe_n, 1'b0);
		buck_oc_raw <= 1'b0;
		rd(FET, 32'h40);
		rd(SUM, 32'h41);
		cy(int'(mdfp_pkg::BK_RETRY_CYC));
		b1(buck_en, 1'b1);
		rd(FET, 32'h0);
		wr(CTL, 32'h40);
		done("buck");
		warn_below_hys <= 1'b0;
		warn_above_trip <= 1'b1;
		cy(4);
		b1(fault_out_low_oe_n, 1'b1);
		rd(THM, 32'h01);
		rd(SUM, 32'h02, 32'h02);
		wr(CTL, 32'h20);
		cy(3);
		b1(fault_out_low_oe_n, 1'b0);
		wr(CTL, 32'h60);
		rd(THM, 32'h01);
		warn_above_trip <= 1'b0;
		cy(4);
		b1(fault_out_low_oe_n, 1'b0);
		warn_below_hys <= 1'b1;
		cy(4);
		b1(fault_out_low_oe_n, 1'b1);
		wr(CTL, 32'h40);
		rd(THM, 32'h0);
		done("warning");
		tsd_fet_hot <= 1'b1;
		cy(4);
		gt(32'h0);
		b1(charge_pump_en, 1'b0);
		b1(buck_en, 1'b1);
		b1(fault_out_low_oe_n, 1'b0);
		rd(SUM, 32'h03, 32'h03);
		tsd_fet_hot <= 1'b0;
		tsd_die_hot <= 1'b1;
		cy(4);
		b1(buck_en, 1'b0);
		tsd_die_hot <= 1'b0;
		cy(4);
		gt(RUNG);
		rd(THM, 32'h02);
		wr(CTL, 32'h40);
		rd(THM, 32'h0);
		done("shutdown");
		mcu.kill(1'b1);
		oc_raw <= 6'h04;
		cy(200);
		gt(32'h0);
		oc_raw <= 6'h00;
		mcu.kill(1'b0);
		cy(3);
		gt(RUNG);
		rd(FET, 32'h0);
		wr(CTL, 32'h43);
		done("kill");
		oc_raw <= 6'h02;
		cy(160);
		oc_raw <= 6'h00;
		rd(FET, 32'h02);
		mcu.pulse(100);
		cy(4);
		rd(FET, 32'h0);
		rd(CTL, 32'h03);
		pstrb <= 4'hE;
		wr(CTL, 32'h10);
		pstrb <= 4'hF;
		rd(CTL, 32'h03);
		wr(CTL, 32'h13);
		oc_raw <= 6'h08;
		cy(200);
		b1(fault_out_low_oe_n, 1'b1);
		cy(110);
		b1(fault_out_low_oe_n, 1'b0);
		gt(32'h0);
		oc_raw <= 6'h00;
		wr(CTL, 32'h53);
		cy(3);
		gt(RUNG);
		mcu.pin(1'b0);
		cy(600);
		b1(fault_out_low_oe_n, 1'b0);
		cy(500);
		b1(asleep, 1'b1);
		b1(regulators_en, 1'b0);
		gt(32'h0);
		mcu.pin(1'b1);
		cy(10);
		b1(fault_out_low_oe_n, 1'b0);
		cy(int'(mdfp_pkg::WAKE_CYC));
		b1(regulators_en, 1'b1);
		b1(fault_out_low_oe_n, 1'b1);
		rd(CTL, 32'h0);
		gt(RUNG);
		done("sleep");
		finish_test();
	end
endmodule // mdfp_bench
`default_nettype wire
